/* File: bench/gcr_frame_monitor.sv */
// Checker for the frame reporter serial line and warm-up flag.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module gcr_frame_monitor #(
  parameter int FRAME_CYCLES = 1000
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [15:0] conc,
  input wire logic        over_range,
  input wire logic        circuit_fault,
  input wire logic        txd,
  input wire logic        warming
);
  // ****************
  // Line and warm-up checks
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] wcnt;
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) wcnt <= 16'h0000;
    else if (warming) wcnt <= wcnt + 16'h0001;
  sequence s_lo; !txd [*8]; endsequence
  sequence s_hi; txd [*8]; endsequence
  property p_fall; $fell(txd) |=> s_lo; endproperty
  property p_rise; $rose(txd) |=> s_hi; endproperty
  property p_stop; $fell(txd) |-> ##[1:160] $rose(txd); endproperty
  property p_next; $rose(txd) |-> ##[1:FRAME_CYCLES] $fell(txd); endproperty
  property p_warm; !warming |=> !warming; endproperty
  property p_wlen; wcnt <= 4 * FRAME_CYCLES; endproperty
  property p_widle; $fell(warming) |-> $past(txd, 100); endproperty
  property p_wgo; $fell(warming) |-> ##[1:20] $fell(txd); endproperty
  a_fall: assert property (p_fall) else $error("short low bit");
  a_rise: assert property (p_rise) else $error("short high bit");
  a_stop: assert property (p_stop) else $error("no stop bit");
  a_next: assert property (p_next) else $error("line silent");
  a_warm: assert property (p_warm) else $error("warm-up again");
  a_wlen: assert property (p_wlen) else $error("warm-up too long");
  a_widle: assert property (p_widle) else $error("warm end in frame");
  a_wgo: assert property (p_wgo) else $error("no frame at warm end");
endmodule // gcr_frame_monitor
bind gcr_frame_reporter gcr_frame_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) u_mon (
  .core_clk(core_clk), .rst_n(rst_n), .conc(conc), .over_range(over_range),
  .circuit_fault(circuit_fault), .txd(txd), .warming(warming));

/* File: bench/gcr_host_rx.sv */
// Host model: 8N1 receiver that samples mid-bit.
// Assumes the line idles high and a bit lasts BIT clock cycles.
`timescale 1ns/1ps
module gcr_host_rx #(
  parameter int BIT = 16
) (
  input  wire logic       clk,
  input  wire logic       rxd,
  output logic [7:0]      rx_byte,
  output logic            got,
  output logic            ferr,
  output logic [7:0]      good_frames
);
  integer i;
  logic [2:0] pos;
  logic [7:0] csum;
  initial begin
    got = 1'b0;
    pos = 3'h0;
    csum = 8'h00;
    good_frames = 8'h00;
  end
  always begin
    @(negedge rxd);
    repeat (BIT / 2) @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      repeat (BIT) @(posedge clk);
      rx_byte[i] = rxd;
    end
    repeat (BIT) @(posedge clk);
    ferr = !rxd;
    // Hunt for the header, then keep a frame only if its checksum matches
    if (pos == 3'h0 && rx_byte != 8'hAA) pos = 3'h0;
    else if (pos == 3'h4) begin
      if (rx_byte == csum) good_frames = good_frames + 8'h01;
      pos = 3'h0;
    end else begin
      csum = (pos == 3'h0) ? rx_byte : csum + rx_byte;
      pos = pos + 3'h1;
    end
    got = 1'b1;
    #2 got = 1'b0;
  end
endmodule // gcr_host_rx

/* File: bench/tb.sv */
// Bench for the frame reporter with short bit, frame and warm-up counts.
// Assumes the host model decodes every byte on txd.
`timescale 1ns/1ps
module tb;
  localparam FC = 1000;
  logic core_clk, rst_n, over_range, circuit_fault, txd, warming, got, ferr;
  logic [15:0] conc;
  logic [7:0]  rx_byte;
  logic [7:0]  good_frames;
  integer fail_count, checks;
  time t0, t_rel;
  gcr_frame_reporter #(.FRAME_CYCLES(FC), .BIT_CYCLES(16), .WARMUP_FRAMES(8'h03)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .conc(conc), .over_range(over_range),
    .circuit_fault(circuit_fault), .txd(txd), .warming(warming));
  gcr_host_rx #(.BIT(16)) i_host (.clk(core_clk), .rxd(txd), .rx_byte(rx_byte),
    .got(got), .ferr(ferr), .good_frames(good_frames));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] act, input logic [31:0] exp);
    checks = checks + 1;
    if (act !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h exp %h", $time, act, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Sum is self-determined 8 bits, so the carry drops out
  task frame(input logic [7:0] st, input logic [15:0] c);
    integer k;
    logic [39:0] e;
    e = {8'hAA, st, c, 8'hAA + st + c[15:8] + c[7:0]};
    for (k = 0; k < 5; k = k + 1) begin
      @(posedge got);
      if (k == 0 && t0 == 0) chk(($time - t_rel) < FC * 8, 1'b1);
      if (k == 0 && t0 != 0) chk($time - t0, FC * 8);
      if (k == 0) t0 = $time;
      chk(rx_byte, e[39 - 8 * k -: 8]);
      chk(ferr, 1'b0);
    end
  endtask
  task set_in(input logic [15:0] c, input logic ov, input logic cf);
    @(posedge core_clk);
    #1 conc = c;
    over_range = ov;
    circuit_fault = cf;
  endtask
  task warm_up;
    integer j;
    set_in(16'h1234, 1'b1, 1'b1);
    for (j = 0; j < 3; j = j + 1) begin
      frame(8'h82, 16'h0000);
      chk(warming, 1'b1);
    end
  endtask
  task normal_run;
    set_in(16'h01F4, 1'b0, 1'b0);
    frame(8'h80, 16'h01F4);
    chk(warming, 1'b0);
    set_in(16'h01F4, 1'b0, 1'b1);
    frame(8'h81, 16'h01F4);
    set_in(16'h0042, 1'b1, 1'b0);
    frame(8'h80, 16'hFFFF);
  endtask
  initial begin
    fail_count = 0;
    checks = 0;
    t0 = 0;
    rst_n = 1'b0;
    conc = 16'h0000;
    over_range = 1'b0;
    circuit_fault = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_rel = $time;
    chk(txd, 1'b1);
    chk(warming, 1'b1);
    warm_up;
    normal_run;
    chk(good_frames, 32'h6);
    end_of_test;
  end
  initial begin
    #(FC * 8 * 12);
    fail_count = fail_count + 1;
    end_of_test;
  end
endmodule // tb

/* File: verilog/gcr_frame_reporter.v */
// Top of the gas concentration frame reporter: warm-up timing and frame upload.
// Assumes concentration and status inputs are synchronous to core_clk.
//
// What this block does
// [RULE1] Stay in warm-up about thirty seconds after reset, then go normal.
// [RULE2] Send one unrequested frame every second from reset, warm-up included.
// [RULE3] Line runs 4800 baud, eight data bits, one stop bit, no parity.
// [RULE4] Frame is five bytes: 0xAA, status, conc high, conc low, checksum.
// [RULE5] Checksum is header plus status plus both concentration bytes.
// [RULE6] Checksum keeps only the low eight bits of the sum.
// [RULE7] Status is 0x80 normal, 0x81 circuit fault, 0x82 warming up.
// [RULE8] Concentration bytes are zero in every warm-up frame.
// [RULE9] Over-range sends concentration 0xFFFF outside warm-up.
// [RULE10] Host aligns on 0xAA and drops frames with bad checksum.
`timescale 1ns/1ps
`include "gcr_regs.vh"
module gcr_frame_reporter #(
  parameter [31:0] FRAME_CYCLES  = `GCR_FRAME_CYCLES,
  parameter [31:0] BIT_CYCLES    = `GCR_BIT_CYCLES,
  parameter [7:0]  WARMUP_FRAMES = `GCR_WARMUP_FRAMES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Measurement
  input  wire [15:0] conc,
  input  wire        over_range,
  input  wire        circuit_fault,
  // Serial out
  output reg         txd,
  output reg         warming
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOAD = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;

  reg  [1:0]  rst_sync;
  wire        rst_core_n = rst_sync[1];
  reg  [31:0] tick_cnt;
  wire        period_end;
  reg         tick;
  reg  [7:0]  warm_cnt;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [2:0]  byte_idx;
  reg  [2:0]  next_byte_idx;
  reg  [7:0]  frame [0:4];
  wire        capture;
  reg         tx_start;
  reg         next_tx_start;
  reg  [7:0]  tx_data;
  reg  [7:0]  next_tx_data;
  wire        tx_line;
  wire        tx_busy;
  reg  [7:0]  next_status;
  reg  [15:0] next_conc;
  reg  [7:0]  next_sum;
  // ****************************************
  // Field decoding
  // ****************************************
  // Warm-up outranks a fault: the reading is not trusted yet
  function [7:0] status_code;
    input warm;
    input fault;
    begin
      if (warm) status_code = `GCR_ST_WARMUP; // [RULE7]
      else if (fault) status_code = `GCR_ST_FAULT; // [RULE7]
      else status_code = `GCR_ST_NORMAL; // [RULE7]
    end
  endfunction

  function [15:0] conc_field;
    input        warm;
    input        over;
    input [15:0] value;
    begin
      if (warm) conc_field = `GCR_CONC_ZERO; // [RULE8]
      else if (over) conc_field = `GCR_CONC_OVER; // [RULE9]
      else conc_field = value;
    end
  endfunction

  // Sum wraps in eight bits, so the carry out is simply lost
  function [7:0] sum8;
    input [7:0] a;
    input [7:0] b;
    begin
      sum8 = a + b; // [RULE6]
    end
  endfunction
  // ****************************************
  // Reset release
  // ****************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rst_sync <= 2'h0;
    else        rst_sync <= {rst_sync[0], 1'b1};
  end
  // ****************************************
  // One-second tick
  // ****************************************
  assign period_end = (tick_cnt == FRAME_CYCLES - 32'h1);
  // First tick comes right after reset so the host sees a frame at once
  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'h0); // [RULE2]
      if (period_end) begin
        tick_cnt <= 32'h0;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
    end
  end
  // ****************************************
  // Warm-up
  // ****************************************
  // Counted in whole frame periods, so the first normal frame opens a period
  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      warm_cnt <= 8'h00;
      warming  <= 1'b1;
    end else if (period_end && warming) begin
      warm_cnt <= warm_cnt + 8'h01;
      if (warm_cnt == WARMUP_FRAMES - 8'h01) begin
        warming <= 1'b0; // [RULE1]
      end
    end
  end
  // ****************************************
  // Frame content
  // ****************************************
  always @* begin
    next_status = status_code(warming, circuit_fault);
    next_conc   = conc_field(warming, over_range, conc);
    next_sum    = sum8(`GCR_HEADER, next_status); // [RULE5]
    next_sum    = sum8(next_sum, next_conc[15:8]); // [RULE5]
    next_sum    = sum8(next_sum, next_conc[7:0]); // [RULE5]
  end
  // ****************************************
  // Frame store
  // ****************************************
  // Fields are frozen at the tick so a mid-frame input change cannot tear the checksum
  assign capture = tick && (state == S_IDLE);
  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      frame[0] <= 8'h00;
      frame[1] <= 8'h00;
      frame[2] <= 8'h00;
      frame[3] <= 8'h00;
      frame[4] <= 8'h00;
    end else if (capture) begin
      frame[0] <= `GCR_HEADER; // [RULE4]
      frame[1] <= next_status; // [RULE4]
      frame[2] <= next_conc[15:8]; // [RULE4]
      frame[3] <= next_conc[7:0]; // [RULE4]
      frame[4] <= next_sum; // [RULE4]
    end
  end
  // ****************************************
  // Frame sequencer
  // ****************************************
  // A tick during a frame is skipped; at 4800 baud a frame takes ~10 ms
  always @* begin
    next_state    = state;
    next_byte_idx = byte_idx;
    next_tx_start = 1'b0;
    next_tx_data  = tx_data;
    case (state)
      S_IDLE: begin
        if (tick) begin
          next_byte_idx = 3'h0;
          next_state    = S_LOAD;
        end
      end
      S_LOAD: begin
        if (!tx_busy && !tx_start) begin
          next_tx_data  = frame[byte_idx];
          next_tx_start = 1'b1;
          next_state    = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!tx_busy && !tx_start) begin
          if (byte_idx == `GCR_LAST_BYTE) begin
            next_state = S_IDLE; // [RULE4]
          end else begin
            next_byte_idx = byte_idx + 3'h1;
            next_state    = S_LOAD;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state    <= S_IDLE;
      byte_idx <= 3'h0;
      tx_start <= 1'b0;
      tx_data  <= 8'h00;
    end else begin
      state    <= next_state;
      byte_idx <= next_byte_idx;
      tx_start <= next_tx_start;
      tx_data  <= next_tx_data;
    end
  end

  // Line is re-registered so the pin comes straight from a flop
  always @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      txd <= 1'b1;
    end else begin
      txd <= tx_line;
    end
  end
  // ****************************************
  // Transmitter
  // ****************************************
  gcr_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .clk   (core_clk),
    .rst_n (rst_core_n),
    .start (tx_start),
    .data  (tx_data),
    .txd   (tx_line),
    .busy  (tx_busy)
  );
endmodule // gcr_frame_reporter

/* File: verilog/gcr_regs.vh */
// Constants for the gas concentration frame reporter.
// Assumes a single 125 MHz core clock.
`ifndef GCR_REGS_VH
`define GCR_REGS_VH
// ****************************************
// Clock and timing
// ****************************************
`define GCR_CLK_HZ          125000000
`define GCR_BAUD            4800
`define GCR_BIT_CYCLES      (`GCR_CLK_HZ / `GCR_BAUD)
`define GCR_FRAME_PERIOD_S  1
`define GCR_FRAME_CYCLES    (`GCR_CLK_HZ * `GCR_FRAME_PERIOD_S)
`define GCR_WARMUP_S        30
`define GCR_WARMUP_FRAMES   (`GCR_WARMUP_S / `GCR_FRAME_PERIOD_S)
// ****************************************
// Frame layout
// ****************************************
`define GCR_FRAME_BYTES     5
`define GCR_LAST_BYTE       3'h4
`define GCR_HEADER          8'hAA
`define GCR_ST_NORMAL       8'h80
`define GCR_ST_FAULT        8'h81
`define GCR_ST_WARMUP       8'h82
`define GCR_CONC_ZERO       16'h0000
`define GCR_CONC_OVER       16'hFFFF
`define GCR_DATA_BITS       8
`endif

/* File: verilog/gcr_uart_tx.v */
// 8N1 UART transmitter, one byte per start pulse.
// Assumes start is only pulsed while busy is low.
`timescale 1ns/1ps
`include "gcr_regs.vh"
module gcr_uart_tx #(
  parameter [31:0] BIT_CYCLES = `GCR_BIT_CYCLES
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Byte in
  input  wire       start,
  input  wire [7:0] data,
  // Line out
  output reg        txd,
  output reg        busy
);
  reg  [31:0] bit_cnt;
  reg  [3:0]  bit_idx;
  reg  [9:0]  shift;
  // ****************************************
  // Shifter: start bit, 8 data bits LSB first, one stop bit, no parity
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txd     <= 1'b1;
      busy    <= 1'b0;
      bit_cnt <= 32'h0;
      bit_idx <= 4'h0;
      shift   <= 10'h3FF;
    end else if (!busy) begin
      if (start) begin
        shift   <= {1'b1, data, 1'b0}; // [RULE3]
        txd     <= 1'b0;
        busy    <= 1'b1;
        bit_cnt <= 32'h0;
        bit_idx <= 4'h0;
      end
    end else if (bit_cnt == BIT_CYCLES - 32'h1) begin
      bit_cnt <= 32'h0;
      if (bit_idx == 4'h9) begin
        busy <= 1'b0;
        txd  <= 1'b1;
      end else begin
        bit_idx <= bit_idx + 4'h1;
        txd     <= shift[bit_idx + 4'h1]; // [RULE3]
      end
    end else begin
      bit_cnt <= bit_cnt + 32'h1;
    end
  end
endmodule // gcr_uart_tx
